/* spr_pkg.sv */
// spr_pkg: constants shared by both ends of the sector protection readback link
// assumes a single system clock on both ends; pins cross into it through synchronisers
package spr_pkg;
    // clock and link timing
    localparam int CLK_MHZ      = 50;
    localparam int SCK_HALF_NS  = 200;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;

    // commands
    localparam logic [7:0] OP_WR_STATUS   = 8'h01;
    localparam logic [7:0] OP_RD_STATUS   = 8'h05;
    localparam logic [7:0] OP_PROT_SECT   = 8'h36;
    localparam logic [7:0] OP_UNPROT_SECT = 8'h39;
    localparam logic [7:0] OP_READ_PROT   = 8'h3c;

    // frame bit counts
    localparam logic [5:0] BITS_OP   = 6'h08;
    localparam logic [5:0] BITS_WRSR = 6'h10;
    localparam logic [5:0] BITS_ADDR = 6'h20;
    localparam logic [5:0] CNT_MAX   = 6'h3f;

    // sector map
    localparam int NUM_SECTORS = 32;
    localparam int SECTOR_LSB  = 16;

    // status byte layout
    localparam int SR_LOCK_BIT = 7;
    localparam int SR_WP_BIT   = 4;
    localparam int SR_SUM_HI   = 3;
    localparam int SR_SUM_LO   = 2;
    localparam int GLOBAL_HI   = 5;
    localparam int GLOBAL_LO   = 2;
    localparam logic [3:0] GLOBAL_PROT   = 4'hf;
    localparam logic [3:0] GLOBAL_UNPROT = 4'h0;
    localparam logic [1:0] SUM_NONE = 2'h0;
    localparam logic [1:0] SUM_SOME = 2'h1;
    localparam logic [1:0] SUM_ALL  = 2'h3;

    // readback bytes
    localparam logic [7:0] BYTE_PROT   = 8'hff;
    localparam logic [7:0] BYTE_UNPROT = 8'h00;

    // values after reset
    localparam logic PROT_RESET = 1'b1;
    localparam logic LOCK_RESET = 1'b0;
endpackage

/* spr_spi_if.sv */
// spr_spi_if: serial pins between host and device
// assumes the serial output line is pulled high while the device does not drive it
`timescale 1ns/1ps
`default_nettype none
interface spr_spi_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic wp_n;
    wire  so_line;

    // released line reads as the pull-up level
    assign so_line = so_oe ? so : 1'b1;

    modport dev (input cs_n, input sck, input si, input wp_n, output so, output so_oe);
    modport host (output cs_n, output sck, output si, output wp_n, input so_line);
endinterface
`default_nettype wire

/* spr_dev.sv */
// spr_dev: device end, sector protection bits, lock bit, status and readback
// assumes sck half period of at least 8 mclk_i cycles; all pins are synchronised
`timescale 1ns/1ps
`default_nettype none
// How it works
// - lock set, protect pin high: globals ignored
// - soft lock still allows lock bit clear
// - host repeats status write for global change
// - host asserts select then sends 3Ch
// - three address bytes pick the sector
// - output a bit every clock after address
// - repeat FFh protected, 00h unprotected
// - fast clock: host discards first byte; spr_host reports every byte read
// - select release ends read, output released
// - select may rise at any bit
// - readback ignores the protect pin level
// - status shows all, some or none protected
// - hardware lock ignores all protection writes
module spr_dev #(
    parameter int NUM_SECTORS = spr_pkg::NUM_SECTORS
) (
    input  wire logic                   mclk_i,     // system clock
    input  wire logic                   rst_b_i,    // async reset, active low
    spr_spi_if.dev                      spi,        // serial pins
    output logic [NUM_SECTORS-1:0]      prot_map_o, // sector protection bits
    output logic                        lock_o      // protection_regs_lock_bit
);
    import spr_pkg::*;

    localparam int SEC_W = $clog2(NUM_SECTORS);

    logic [1:0]             cs_sy_r;
    logic [1:0]             sck_sy_r;
    logic [1:0]             si_sy_r;
    logic [1:0]             wp_sy_r;
    logic                   cs_d_r;
    logic                   sck_d_r;
    logic [5:0]             cnt_r;
    logic [31:0]            frame_r;
    logic [7:0]             op_r;
    logic [7:0]             wdat_r;
    logic [7:0]             out_sr_r;
    logic [23:0]            addr_r;
    logic                   have_addr_r;
    logic                   have_data_r;
    logic                   out_en_r;
    logic                   so_r;
    logic                   so_oe_r;
    logic                   lock_r;
    logic                   lock_nxt;
    logic [NUM_SECTORS-1:0] prot_r;
    logic [NUM_SECTORS-1:0] prot_nxt;
    logic [7:0]             status_byte;

    function automatic logic [SEC_W-1:0] sect_idx(input logic [23:0] a);
        sect_idx = a[SECTOR_LSB +: SEC_W];
    endfunction

    // frame decode
    wire        cs_act    = ~cs_sy_r[1];
    // every write commits on the synchronised select release
    wire        cs_end    = cs_sy_r[1] & ~cs_d_r;
    wire        sck_rise  = cs_act & sck_sy_r[1] & ~sck_d_r;
    wire        sck_fall  = cs_act & ~sck_sy_r[1] & sck_d_r;
    // count saturates so a long readback never wraps into the header bits
    wire [5:0]  cnt_inc   = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 6'h01;
    wire [31:0] frame_nxt = {frame_r[30:0], si_sy_r[1]};
    wire        op_done   = sck_rise & (cnt_inc == BITS_OP);
    wire        data_done = sck_rise & (cnt_inc == BITS_WRSR);
    wire        addr_done = sck_rise & (cnt_inc == BITS_ADDR);
    wire        rd_status = op_done & (frame_nxt[7:0] == OP_RD_STATUS);
    wire        rd_prot   = addr_done & (op_r == OP_READ_PROT);

    // protection state decode
    // hard lock needs the pin asserted; soft lock keeps the lock bit writable
    wire        hw_lock   = lock_r & ~wp_sy_r[1];
    wire        all_prot  = &prot_r;
    wire        none_prot = ~|prot_r;
    wire [1:0]  summary   = all_prot ? SUM_ALL : (none_prot ? SUM_NONE : SUM_SOME);
    wire        rd_bit    = prot_r[sect_idx(frame_nxt[23:0])];
    wire [7:0]  rd_byte   = rd_bit ? BYTE_PROT : BYTE_UNPROT;
    wire [3:0]  glob      = wdat_r[GLOBAL_HI:GLOBAL_LO];
    wire        wrsr_go   = cs_end & have_data_r & (op_r == OP_WR_STATUS) & ~hw_lock;
    wire        sect_go   = cs_end & have_addr_r & ~lock_r;
    wire        prot_go   = sect_go & (op_r == OP_PROT_SECT);
    wire        unprot_go = sect_go & (op_r == OP_UNPROT_SECT);

    always_comb begin
        status_byte = 8'h00;
        status_byte[SR_LOCK_BIT] = lock_r;
        status_byte[SR_WP_BIT] = wp_sy_r[1];
        status_byte[SR_SUM_HI:SR_SUM_LO] = summary;
    end

    // the lock value before the write gates the global pattern, so clearing
    // the lock and changing all sectors takes two separate writes
    always_comb begin
        prot_nxt = prot_r;
        lock_nxt = lock_r;
        if (wrsr_go) begin
            lock_nxt = wdat_r[SR_LOCK_BIT];
            if (!lock_r && glob == GLOBAL_PROT) begin
                prot_nxt = '1;
            end else if (!lock_r && glob == GLOBAL_UNPROT) begin
                prot_nxt = '0;
            end
        end else if (prot_go) begin
            prot_nxt[sect_idx(addr_r)] = 1'b1;
        end else if (unprot_go) begin
            prot_nxt[sect_idx(addr_r)] = 1'b0;
        end
    end

    // pin synchronisers and edge history
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // presets match the idle pins, so no false edge follows reset
            cs_sy_r  <= 2'h3;
            sck_sy_r <= 2'h0;
            si_sy_r  <= 2'h0;
            wp_sy_r  <= 2'h3;
            cs_d_r   <= 1'b1;
            sck_d_r  <= 1'b0;
        end else begin
            cs_sy_r  <= {cs_sy_r[0], spi.cs_n};
            sck_sy_r <= {sck_sy_r[0], spi.sck};
            si_sy_r  <= {si_sy_r[0], spi.si};
            wp_sy_r  <= {wp_sy_r[0], spi.wp_n};
            cs_d_r   <= cs_sy_r[1];
            sck_d_r  <= sck_sy_r[1];
        end
    end

    // command frame capture
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r       <= 6'h00;
            frame_r     <= 32'h0000_0000;
            op_r        <= 8'h00;
            wdat_r      <= 8'h00;
            addr_r      <= 24'h00_0000;
            have_addr_r <= 1'b0;
            have_data_r <= 1'b0;
            out_en_r    <= 1'b0;
            out_sr_r    <= 8'h00;
        end else if (!cs_act) begin
            cnt_r       <= 6'h00;
            have_addr_r <= 1'b0;
            have_data_r <= 1'b0;
            out_en_r    <= 1'b0;
        end else if (sck_rise) begin
            cnt_r   <= cnt_inc;
            frame_r <= frame_nxt;
            if (op_done) begin
                op_r <= frame_nxt[7:0];
            end
            if (data_done) begin
                wdat_r      <= frame_nxt[7:0];
                have_data_r <= 1'b1;
            end
            if (addr_done) begin
                addr_r      <= frame_nxt[23:0];
                have_addr_r <= 1'b1;
            end
            if (rd_status) begin
                out_en_r <= 1'b1;
                out_sr_r <= status_byte;
            end
            if (rd_prot) begin
                out_en_r <= 1'b1;
                out_sr_r <= rd_byte;
            end
        end else if (sck_fall && out_en_r) begin
            // rotate so the same byte repeats while select stays low
            out_sr_r <= {out_sr_r[6:0], out_sr_r[7]};
        end
    end

    // serial output, changes after falling edges only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else if (!cs_act) begin
            so_oe_r <= 1'b0;
        end else if (sck_fall && out_en_r) begin
            so_r    <= out_sr_r[7];
            // drive starts with the first shifted bit, not with the load
            so_oe_r <= 1'b1;
        end
    end

    // protection bits and lock bit
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // all sectors come up protected and unlocked
            prot_r <= {NUM_SECTORS{PROT_RESET}};
            lock_r <= LOCK_RESET;
        end else begin
            prot_r <= prot_nxt;
            lock_r <= lock_nxt;
        end
    end

    assign spi.so     = so_r;
    assign spi.so_oe  = so_oe_r;
    assign prot_map_o = prot_r;
    assign lock_o     = lock_r;
endmodule
`default_nettype wire

/* spr_host.sv */
// spr_host: host end, runs one framed command with write and read bytes
// assumes the device answers within a sck half period; sck idles low
`timescale 1ns/1ps
`default_nettype none
module spr_host #(
    parameter int HALF_CYC = spr_pkg::SCK_HALF_CYC
) (
    input  wire logic        mclk_i,      // system clock
    input  wire logic        rst_b_i,     // async reset, active low
    spr_spi_if.host          spi,         // serial pins
    input  wire logic        cmd_valid_i, // start a command, taken when idle
    input  wire logic [7:0]  cmd_op_i,    // opcode
    input  wire logic [31:0] cmd_tx_i,    // bytes after opcode, first in [31:24]
    input  wire logic [2:0]  cmd_ntx_i,   // bytes sent after opcode, 0..4
    input  wire logic [3:0]  cmd_nrx_i,   // bytes read afterwards
    input  wire logic        wp_n_i,      // protect pin level, active low
    output logic             busy_o,      // command in progress
    output logic             done_o,      // pulse, command finished
    output logic [7:0]       rdata_o,     // last byte read
    output logic             rdata_vld_o  // pulse, rdata_o new
);
    import spr_pkg::*;

    localparam int DIV_W = $clog2(HALF_CYC + 1);
    localparam logic [DIV_W-1:0] HALF_M1 = DIV_W'(HALF_CYC - 1);

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LEAD = 3'b001,
        HS_HI   = 3'b010,
        HS_LO   = 3'b011,
        HS_TAIL = 3'b100,
        HS_GAP  = 3'b101
    } spr_hstate_type;

    spr_hstate_type   st_r;
    logic [DIV_W-1:0] div_r;
    logic [39:0]      tx_r;
    logic [7:0]       bits_r;
    logic [7:0]       tot_r;
    logic [7:0]       txbits_r;
    logic [7:0]       rx_r;
    logic [1:0]       so_sy_r;
    logic             sck_r;
    logic             cs_n_r;
    logic             si_r;
    logic             wp_n_r;
    logic             busy_r;
    logic             done_r;
    logic [7:0]       rdata_r;
    logic             rvld_r;

    wire        half_done = (div_r == HALF_M1);
    wire [4:0]  nbytes    = 5'h01 + {2'h0, cmd_ntx_i} + {1'h0, cmd_nrx_i};
    wire [3:0]  ntxb      = 4'h1 + {1'h0, cmd_ntx_i};
    wire [7:0]  rx_nxt    = {rx_r[6:0], so_sy_r[1]};
    wire [7:0]  bits_inc  = bits_r + 8'h01;
    wire        rx_byte   = (bits_r >= txbits_r) && (bits_r[2:0] == 3'h7);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            so_sy_r <= 2'h3;
            wp_n_r  <= 1'b1;
        end else begin
            so_sy_r <= {so_sy_r[0], spi.so_line};
            wp_n_r  <= wp_n_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r     <= HS_IDLE;
            div_r    <= '0;
            tx_r     <= 40'h00_0000_0000;
            bits_r   <= 8'h00;
            tot_r    <= 8'h00;
            txbits_r <= 8'h00;
            rx_r     <= 8'h00;
            sck_r    <= 1'b0;
            cs_n_r   <= 1'b1;
            si_r     <= 1'b0;
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            rdata_r  <= 8'h00;
            rvld_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            rvld_r <= 1'b0;
            div_r  <= half_done ? '0 : div_r + DIV_W'(1);
            case (st_r)
                HS_IDLE: begin
                    div_r <= '0;
                    if (cmd_valid_i) begin
                        tx_r     <= {cmd_op_i, cmd_tx_i};
                        tot_r    <= {nbytes, 3'h0};
                        txbits_r <= {1'h0, ntxb, 3'h0};
                        bits_r   <= 8'h00;
                        cs_n_r   <= 1'b0;
                        si_r     <= cmd_op_i[7];
                        busy_r   <= 1'b1;
                        st_r     <= HS_LEAD;
                    end
                end
                HS_LEAD, HS_LO: begin
                    if (half_done) begin
                        sck_r <= 1'b1;
                        rx_r  <= rx_nxt;
                        if (rx_byte) begin
                            rdata_r <= rx_nxt;
                            rvld_r  <= 1'b1;
                        end
                        st_r <= HS_HI;
                    end
                end
                HS_HI: begin
                    if (half_done) begin
                        sck_r  <= 1'b0;
                        bits_r <= bits_inc;
                        tx_r   <= {tx_r[38:0], 1'b0};
                        si_r   <= tx_r[38];
                        st_r   <= (bits_inc == tot_r) ? HS_TAIL : HS_LO;
                    end
                end
                HS_TAIL: begin
                    if (half_done) begin
                        cs_n_r <= 1'b1;
                        st_r   <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    if (half_done) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        st_r   <= HS_IDLE;
                    end
                end
                default: begin
                    st_r <= HS_IDLE;
                end
            endcase
        end
    end

    assign spi.cs_n    = cs_n_r;
    assign spi.sck     = sck_r;
    assign spi.si      = si_r;
    assign spi.wp_n    = wp_n_r;
    assign busy_o      = busy_r;
    assign done_o      = done_r;
    assign rdata_o     = rdata_r;
    assign rdata_vld_o = rvld_r;
endmodule
`default_nettype wire

/* spr_link_properties.sv */
// spr_link_properties: checks on the serial pins between host and device ends
// assumes host sck half period of at least 8 mclk_i cycles
`timescale 1ns/1ps
`default_nettype none
module spr_link_properties (
    input  wire logic mclk_i,  // system clock
    input  wire logic rst_b_i, // async reset, active low
    input  wire logic cs_n,    // chip select, active low
    input  wire logic sck,     // serial clock
    input  wire logic si,      // host to device data
    input  wire logic so,      // device data
    input  wire logic so_oe,   // device drives so
    input  wire logic wp_n     // protect pin, active low
);
    import spr_pkg::*;

    logic [5:0] bit_cnt_r;
    logic [7:0] op_r;
    logic       sck_d_r;
    wire        sck_rise = sck & ~sck_d_r;

    // bits seen on sck rises in the current frame, and the opcode
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_r <= 6'h00;
            op_r      <= 8'h00;
            sck_d_r   <= 1'b0;
        end else begin
            sck_d_r <= sck;
            if (cs_n)
                bit_cnt_r <= 6'h00;
            else if (sck_rise && bit_cnt_r != CNT_MAX)
                bit_cnt_r <= bit_cnt_r + 6'h01;
            if (!cs_n && sck_rise && bit_cnt_r < BITS_OP)
                op_r <= {op_r[6:0], si};
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_rel_bound;
        $rose(cs_n) |-> ##[1:6] !so_oe;
    endproperty
    a_rel_bound: assert property (p_rel_bound)
        else $error("output not released after select rise");
    property p_idle_off;
        cs_n [*4] |-> !so_oe;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("output driven while deselected");
    property p_oe_hold;
        so_oe && !cs_n |=> so_oe;
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("output dropped inside frame");
    property p_oe_cause;
        $rose(so_oe) |-> !cs_n && bit_cnt_r == (op_r == OP_READ_PROT ? BITS_ADDR : BITS_OP);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("output started at wrong bit");
    property p_read_const;
        so_oe && $past(so_oe) && op_r == OP_READ_PROT |-> $stable(so);
    endproperty
    a_read_const: assert property (p_read_const)
        else $error("readback bits not all equal");
    property p_so_fall_only;
        so_oe && $past(so_oe) && sck && $past(sck) |-> $stable(so);
    endproperty
    a_so_fall_only: assert property (p_so_fall_only)
        else $error("output changed while sck high");
    property p_si_low;
        $changed(si) && !cs_n |-> !sck;
    endproperty
    a_si_low: assert property (p_si_low)
        else $error("input changed while sck high");
    property p_sck_idle;
        cs_n |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("sck high while deselected");

    c_read: cover property ($rose(so_oe) && op_r == OP_READ_PROT);
    c_status: cover property ($rose(so_oe) && op_r == OP_RD_STATUS);
    c_release: cover property ($rose(cs_n) && so_oe);
    c_hw_lock: cover property (!wp_n && $rose(so_oe));
endmodule
`default_nettype wire

/* test_sector_protect_readback.sv */
// test_sector_protect_readback: host and device ends joined, random and corner commands
// assumes spr_pkg, spr_spi_if, spr_dev, spr_host, spr_link_properties compiled first
`timescale 1ns/1ps
`default_nettype none
module test_sector_protect_readback;
    import spr_pkg::*;
    logic        mclk_i    = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [7:0]  cmd_op    = 8'h00;
    logic [31:0] cmd_tx    = 32'h0;
    logic [2:0]  cmd_ntx   = 3'h0;
    logic [3:0]  cmd_nrx   = 4'h0;
    logic        wp_n      = 1'b1;
    logic        busy, done, vld, lock;
    logic [7:0]  rdata;
    logic [31:0] prot_map;
    logic [31:0] prot_m    = '1;
    logic        lock_m    = 1'b0;
    logic [7:0]  rx_q[$];
    int          errors = 0, n_tests = 0, cycles = 0, seed = 32'h92d9;
    logic [23:0] a;

    spr_spi_if spi ();
    spr_dev spr_dev_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .spi(spi.dev),
        .prot_map_o(prot_map), .lock_o(lock));
    spr_host #(.HALF_CYC(8)) spr_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .spi(spi.host), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_tx_i(cmd_tx),
        .cmd_ntx_i(cmd_ntx), .cmd_nrx_i(cmd_nrx), .wp_n_i(wp_n), .busy_o(busy),
        .done_o(done), .rdata_o(rdata), .rdata_vld_o(vld));
    spr_link_properties spr_link_properties_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .cs_n(spi.cs_n), .sck(spi.sck), .si(spi.si), .so(spi.so), .so_oe(spi.so_oe),
        .wp_n(spi.wp_n));

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (vld === 1'b1)
            rx_q.push_back(rdata);
        cycles++;
        if (cycles == 60000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_status();
        logic [1:0] s;
        s = (prot_m == '1) ? SUM_ALL : ((prot_m == '0) ? SUM_NONE : SUM_SOME);
        return {lock_m, 2'b00, wp_n, s, 2'b00};
    endfunction

    task automatic run(input logic [7:0] op, input logic [31:0] tx, input logic [2:0] ntx,
                       input logic [3:0] nrx);
        int n;
        rx_q.delete();
        @(posedge mclk_i);
        cmd_op    <= op;
        cmd_tx    <= tx;
        cmd_ntx   <= ntx;
        cmd_nrx   <= nrx;
        cmd_valid <= 1'b1;
        @(posedge mclk_i);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (done !== 1'b1 && n < 4000);
        chk(n < 4000, 1);
        chk({31'h0, busy}, 32'h0);
        chk(rx_q.size(), {28'h0, nrx});
        chk(prot_map, prot_m);
        chk({31'h0, lock}, {31'h0, lock_m});
    endtask

    task automatic wr_status(input logic [7:0] d);
        if (!(lock_m && !wp_n)) begin
            if (!lock_m && d[5:2] == GLOBAL_PROT)
                prot_m = '1;
            if (!lock_m && d[5:2] == GLOBAL_UNPROT)
                prot_m = '0;
            lock_m = d[7];
        end
        run(OP_WR_STATUS, {d, 24'h0}, 3'h1, 4'h0);
    endtask

    task automatic sect(input logic [7:0] op, input logic [23:0] ad);
        if (!lock_m)
            prot_m[ad[20:16]] = (op == OP_PROT_SECT);
        run(op, {ad, 8'h00}, 3'h3, 4'h0);
    endtask

    task automatic rd_sect(input logic [23:0] ad);
        run(OP_READ_PROT, {ad, 8'h00}, 3'h3, 4'h2);
        foreach (rx_q[i]) chk(rx_q[i], prot_m[ad[20:16]] ? BYTE_PROT : BYTE_UNPROT);
    endtask

    task automatic rd_status();
        run(OP_RD_STATUS, 32'h0, 3'h0, 4'h3);
        foreach (rx_q[i]) chk(rx_q[i], exp_status());
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        rd_status();
        for (int i = 0; i < 4; i++) rd_sect(24'($random(seed)));
        sect(OP_UNPROT_SECT, 24'h051234);
        rd_sect(24'h05ffff);
        rd_status();
        for (int i = 0; i < 12; i++) begin
            a = 24'($random(seed));
            sect(a[0] ? OP_PROT_SECT : OP_UNPROT_SECT, a);
            rd_sect({a[23:16], 16'($random(seed))});
        end
        wr_status(8'h00);
        rd_status();
        wr_status(8'hbc);
        wr_status(8'h80);
        sect(OP_UNPROT_SECT, 24'($random(seed)));
        wr_status(8'h00);
        wr_status(8'h00);
        rd_status();
        wr_status(8'h84);
        @(posedge mclk_i);
        wp_n <= 1'b0;
        @(posedge mclk_i);
        wr_status(8'h3c);
        sect(OP_PROT_SECT, 24'($random(seed)));
        rd_sect(24'($random(seed)));
        rd_status();
        @(posedge mclk_i);
        wp_n <= 1'b1;
        @(posedge mclk_i);
        wr_status(8'h00);
        rd_status();
        test_done();
    end
endmodule
`default_nettype wire
